/* File: adsq_params.svh */
`ifndef ADSQ_PARAMS_SVH
`define ADSQ_PARAMS_SVH

// register byte offsets
`define ADSQ_OFF_ACTIVE 12'h000
`define ADSQ_OFF_RIS 12'h004
`define ADSQ_OFF_MASK 12'h008
`define ADSQ_OFF_ISC 12'h00C
`define ADSQ_OFF_OVF 12'h010
`define ADSQ_OFF_TRIGSEL 12'h014
`define ADSQ_OFF_UNF 12'h018
`define ADSQ_OFF_PRIO 12'h020
`define ADSQ_OFF_SWINIT 12'h028
`define ADSQ_OFF_AVG 12'h030
// per-sequencer block: base + n * stride, then word index inside it
`define ADSQ_OFF_SEQ_BASE 12'h040
`define ADSQ_OFF_SEQ_END 12'h0C0
`define ADSQ_SEQ_SHIFT 5
`define ADSQ_SUB_MUX 3'h0
`define ADSQ_SUB_CTL 3'h1
`define ADSQ_SUB_FIFO 3'h2
`define ADSQ_SUB_FSTAT 3'h3

// reset values
`define ADSQ_PRIO_RST 16'h3210
`define ADSQ_AVG_RST 3'h0

// trigger source codes
`define ADSQ_TRIG_PROC 4'h0
`define ADSQ_TRIG_ALWAYS 4'hF

// step control nibble bit positions
`define ADSQ_CTL_DIFF 0
`define ADSQ_CTL_END 1
`define ADSQ_CTL_IE 2
`define ADSQ_CTL_TEMP 3

// fifo status bit positions
`define ADSQ_FST_TAIL 0
`define ADSQ_FST_HEAD 4
`define ADSQ_FST_EMPTY 8
`define ADSQ_FST_FULL 12

// averaging: log2 of the largest factor (64)
`define ADSQ_AVG_MAX 3'h6

// timing: converter control clock derived from pclk
`define ADSQ_SYS_HZ 100000000
`define ADSQ_ADC_HZ 16667000
`define ADSQ_CLK_DIV ((`ADSQ_SYS_HZ + `ADSQ_ADC_HZ - 1) / `ADSQ_ADC_HZ)

`endif

/* File: adsq_pkg.sv */
package adsq_pkg;

    typedef enum logic [1:0] {
        ADSQ_IDLE,
        ADSQ_START,
        ADSQ_WAIT
    } adsq_state_t;

    // one conversion request to the analog core
    typedef struct packed {
        logic [3:0] chan;
        logic diff;
        logic temp;
    } adsq_conv_req_t;

    // step descriptor: input nibble and control nibble
    typedef struct packed {
        logic [3:0] sel;
        logic [3:0] ctl;
    } adsq_step_t;

endpackage

/* File: adsq_sequencer.sv */
// Behaviour
// - 10-bit results; six inputs plus temperature sensor
// - four sequencers: depths 8, 4, 4, 1
// - fifo word 32 bits, result in bits 9:0
// - each step: input nibble and control nibble
// - sequencer starts only while enable set, then runs to its last step
// - per-step interrupt enable raises raw interrupt
// - end bit ends sequence, later slots ignored
// - circular fifo, data read pops oldest
// - fifo head, tail, full, empty readable
// - overflow and underflow status registers
// - control tick at about 16.667 MHz
// - mask gates interrupt to controller
// - raw view and masked view of interrupts
// - write one clears interrupt, zero ignored
// - concurrent triggers served by priority value
// - trigger source per sequencer incl. processor, always
// - software initiate starts processor-triggered sequencer
// - averaging up to 64 conversions per entry
// - averaging off after reset
// - one shared averaging circuit for all steps
// - reset priority: sequencer 0 highest, 3 lowest
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/1ns
`include "adsq_params.svh"

module adsq_sequencer
    import adsq_pkg::*;
#(
    parameter int NTRIG = 14,
    parameter int CLK_DIV = `ADSQ_CLK_DIV
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NTRIG-1:0] trig_in,
    output logic conv_start,
    output adsq_conv_req_t conv_req,
    input wire logic conv_done,
    input wire logic [9:0] conv_result,
    output logic [3:0] seq_irq
);

    localparam int NSEQ = 4;

    function automatic logic [3:0] seq_depth(input logic [1:0] n);
        case (n)
            2'd0: seq_depth = 4'd8;
            2'd1, 2'd2: seq_depth = 4'd4;
            default: seq_depth = 4'd1;
        endcase
    endfunction

    function automatic logic [2:0] wrap_inc(input logic [2:0] p, input logic [1:0] n);
        wrap_inc = ({1'b0, p} + 4'd1 == seq_depth(n)) ? 3'd0 : p + 3'd1;
    endfunction

    // ---------------- registers
    logic [3:0] enable_r;
    logic [3:0] ris_r;
    logic [3:0] mask_r;
    logic [3:0] ovf_r;
    logic [3:0] unf_r;
    logic [15:0] trigsel_r;
    logic [15:0] prio_r;
    logic [2:0] avg_r;
    logic [31:0] mux_r [NSEQ];
    logic [31:0] ctl_r [NSEQ];
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    logic rd_empty_r;

    // ---------------- bus decode
    logic setup_ph;
    logic acc_ph;
    logic wr_en;
    logic rd_en;
    logic seq_hit;
    logic [1:0] seq_idx;
    logic [2:0] seq_sub;
    logic [11:0] seq_rel;

    assign setup_ph = psel && !penable;
    assign acc_ph = psel && penable && pready_r;
    assign wr_en = acc_ph && pwrite;
    assign rd_en = acc_ph && !pwrite;
    assign seq_hit = (paddr >= `ADSQ_OFF_SEQ_BASE) && (paddr < `ADSQ_OFF_SEQ_END);
    assign seq_rel = paddr - `ADSQ_OFF_SEQ_BASE;
    assign seq_idx = seq_rel[`ADSQ_SEQ_SHIFT+1:`ADSQ_SEQ_SHIFT];
    assign seq_sub = seq_rel[4:2];

    function automatic logic is_wr(input logic [11:0] off);
        is_wr = wr_en && (paddr == off);
    endfunction

    // ---------------- fifo state
    logic [9:0] fifo_mem [NSEQ][8];
    logic [2:0] wptr_r [NSEQ];
    logic [2:0] rptr_r [NSEQ];
    logic [3:0] cnt_r [NSEQ];
    logic [3:0] push;
    logic [3:0] pop;
    logic [3:0] full;
    logic [3:0] empty;
    logic [9:0] push_data;

    // ---------------- engine state
    adsq_state_t state_r;
    logic [1:0] cur_r;
    logic [2:0] step_r;
    logic [6:0] avg_cnt_r;
    logic [15:0] acc_r;
    logic [3:0] pend_r;
    logic [3:0] grant;
    logic [7:0] cur_step_nib;
    adsq_step_t cur_step;
    logic [15:0] acc_sum;
    logic avg_done;
    logic step_last;

    // ---------------- read mux
    logic [31:0] rd_data;
    logic rd_hit;
    logic [3:0] fst_tail;
    logic [3:0] fst_head;

    always_comb begin
        rd_data = 32'h0000_0000;
        rd_hit = 1'b1;
        fst_tail = {1'b0, wptr_r[seq_idx]};
        fst_head = {1'b0, rptr_r[seq_idx]};
        if (seq_hit) begin
            case (seq_sub)
                `ADSQ_SUB_MUX: rd_data = mux_r[seq_idx];
                `ADSQ_SUB_CTL: rd_data = ctl_r[seq_idx];
                `ADSQ_SUB_FIFO: rd_data = {22'h000000, fifo_mem[seq_idx][rptr_r[seq_idx]]};
                `ADSQ_SUB_FSTAT: begin
                    rd_data[`ADSQ_FST_TAIL +: 4] = fst_tail;
                    rd_data[`ADSQ_FST_HEAD +: 4] = fst_head;
                    rd_data[`ADSQ_FST_EMPTY] = empty[seq_idx];
                    rd_data[`ADSQ_FST_FULL] = full[seq_idx];
                end
                default: rd_hit = 1'b0;
            endcase
        end else begin
            case (paddr)
                `ADSQ_OFF_ACTIVE: rd_data = {28'h0000000, enable_r};
                `ADSQ_OFF_RIS: rd_data = {28'h0000000, ris_r};
                `ADSQ_OFF_MASK: rd_data = {28'h0000000, mask_r};
                `ADSQ_OFF_ISC: rd_data = {28'h0000000, ris_r & mask_r};
                `ADSQ_OFF_OVF: rd_data = {28'h0000000, ovf_r};
                `ADSQ_OFF_TRIGSEL: rd_data = {16'h0000, trigsel_r};
                `ADSQ_OFF_UNF: rd_data = {28'h0000000, unf_r};
                `ADSQ_OFF_PRIO: rd_data = {16'h0000, prio_r};
                `ADSQ_OFF_SWINIT: rd_data = 32'h0000_0000;
                `ADSQ_OFF_AVG: rd_data = {29'h00000000, avg_r};
                default: rd_hit = 1'b0;
            endcase
        end
    end

    // ---------------- apb slave: answer in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
            rd_empty_r <= 1'b0;
        end else begin
            pready_r <= setup_ph;
            if (setup_ph) begin
                pslverr_r <= !rd_hit;
                prdata_r <= pwrite ? 32'h0000_0000 : rd_data;
                rd_empty_r <= empty[seq_idx];
            end else begin
                pslverr_r <= 1'b0;
            end
        end
    end

    // ---------------- control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_r <= 4'h0;
            mask_r <= 4'h0;
            trigsel_r <= 16'h0000;
            prio_r <= `ADSQ_PRIO_RST;
            avg_r <= `ADSQ_AVG_RST;
        end else begin
            if (is_wr(`ADSQ_OFF_ACTIVE)) begin
                enable_r <= pwdata[3:0];
            end
            if (is_wr(`ADSQ_OFF_MASK)) begin
                mask_r <= pwdata[3:0];
            end
            if (is_wr(`ADSQ_OFF_TRIGSEL)) begin
                trigsel_r <= pwdata[15:0];
            end
            if (is_wr(`ADSQ_OFF_PRIO)) begin
                prio_r <= {2'b00, pwdata[13:12], 2'b00, pwdata[9:8], 2'b00, pwdata[5:4],
                           2'b00, pwdata[1:0]};
            end
            if (is_wr(`ADSQ_OFF_AVG)) begin
                avg_r <= (pwdata[2:0] > `ADSQ_AVG_MAX) ? `ADSQ_AVG_MAX : pwdata[2:0];
            end
        end
    end

    // step descriptors
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NSEQ; i++) begin
                mux_r[i] <= 32'h0000_0000;
                ctl_r[i] <= 32'h0000_0000;
            end
        end else if (wr_en && seq_hit) begin
            if (seq_sub == `ADSQ_SUB_MUX) begin
                mux_r[seq_idx] <= pwdata;
            end
            if (seq_sub == `ADSQ_SUB_CTL) begin
                ctl_r[seq_idx] <= pwdata;
            end
        end
    end

    // ---------------- interrupt, overflow, underflow flags; set wins
    logic [3:0] ris_set;
    logic [3:0] ris_clr;
    logic [3:0] ovf_clr;
    logic [3:0] unf_clr;

    assign ris_clr = (wr_en && paddr == `ADSQ_OFF_ISC) ? pwdata[3:0] : 4'h0;
    assign ovf_clr = (wr_en && paddr == `ADSQ_OFF_OVF) ? pwdata[3:0] : 4'h0;
    assign unf_clr = (wr_en && paddr == `ADSQ_OFF_UNF) ? pwdata[3:0] : 4'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ris_r <= 4'h0;
            ovf_r <= 4'h0;
            unf_r <= 4'h0;
            seq_irq <= 4'h0;
        end else begin
            ris_r <= (ris_r & ~ris_clr) | ris_set;
            ovf_r <= (ovf_r & ~ovf_clr) | (push & full);
            unf_r <= (unf_r & ~unf_clr) | (pop & {4{rd_empty_r}});
            seq_irq <= ((ris_r & ~ris_clr) | ris_set) & mask_r;
        end
    end

    // ---------------- result fifos
    generate
        for (genvar g = 0; g < NSEQ; g++) begin : g_fifo
            assign full[g] = (cnt_r[g] == seq_depth(2'(g)));
            assign empty[g] = (cnt_r[g] == 4'd0);
            assign pop[g] = rd_en && seq_hit && (seq_idx == 2'(g)) && (seq_sub == `ADSQ_SUB_FIFO);

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    wptr_r[g] <= 3'd0;
                    rptr_r[g] <= 3'd0;
                    cnt_r[g] <= 4'd0;
                    for (int k = 0; k < 8; k++) begin
                        fifo_mem[g][k] <= 10'h000;
                    end
                end else begin
                    if (push[g] && !full[g]) begin
                        fifo_mem[g][wptr_r[g]] <= push_data;
                        wptr_r[g] <= wrap_inc(wptr_r[g], 2'(g));
                    end
                    if (pop[g] && !rd_empty_r) begin
                        rptr_r[g] <= wrap_inc(rptr_r[g], 2'(g));
                    end
                    cnt_r[g] <= cnt_r[g] + {3'd0, push[g] && !full[g]}
                                - {3'd0, pop[g] && !rd_empty_r};
                end
            end
        end
    endgenerate

    // ---------------- control tick divider
    logic [7:0] div_r;
    logic tick;

    assign tick = (div_r == 8'(CLK_DIV - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r <= 8'h00;
        end else begin
            div_r <= tick ? 8'h00 : div_r + 8'h01;
        end
    end

    // ---------------- trigger inputs: three-flop sync, edge once stable
    logic [NTRIG-1:0] trig_s1_r;
    logic [NTRIG-1:0] trig_s2_r;
    logic [NTRIG-1:0] trig_s3_r;
    logic [NTRIG-1:0] trig_lvl_r;
    logic [NTRIG-1:0] trig_agree;
    logic [NTRIG-1:0] trig_rise;
    logic [3:0] trig_ev;

    assign trig_agree = ~(trig_s2_r ^ trig_s3_r);
    assign trig_rise = trig_agree & trig_s3_r & ~trig_lvl_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_s1_r <= '0;
            trig_s2_r <= '0;
            trig_s3_r <= '0;
            trig_lvl_r <= '0;
        end else begin
            trig_s1_r <= trig_in;
            trig_s2_r <= trig_s1_r;
            trig_s3_r <= trig_s2_r;
            trig_lvl_r <= (trig_lvl_r & ~trig_agree) | (trig_s3_r & trig_agree);
        end
    end

    always_comb begin
        for (int i = 0; i < NSEQ; i++) begin
            case (trigsel_r[4*i +: 4])
                `ADSQ_TRIG_PROC: trig_ev[i] = is_wr(`ADSQ_OFF_SWINIT) && pwdata[i];
                `ADSQ_TRIG_ALWAYS: trig_ev[i] = 1'b1;
                default: trig_ev[i] = (int'(trigsel_r[4*i +: 4]) <= NTRIG)
                                      && trig_rise[trigsel_r[4*i +: 4] - 4'd1];
            endcase
        end
    end

    // pending triggers; a new trigger in the grant cycle is kept
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_r <= 4'h0;
        end else begin
            pend_r <= ((pend_r & ~grant) | trig_ev) & enable_r;
        end
    end

    // ---------------- arbitration: lowest priority value wins
    always_comb begin
        logic [2:0] best;
        best = 3'd4;
        grant = 4'h0;
        for (int p = 0; p < NSEQ; p++) begin
            for (int i = 0; i < NSEQ; i++) begin
                if (best == 3'd4 && pend_r[i] && enable_r[i]
                    && prio_r[4*i +: 2] == 2'(p)) begin
                    best = 3'(i);
                end
            end
        end
        if (state_r == ADSQ_IDLE && tick && best != 3'd4) begin
            grant[best[1:0]] = 1'b1;
        end
    end

    // ---------------- conversion engine
    assign cur_step_nib = {mux_r[cur_r][4*step_r +: 4], ctl_r[cur_r][4*step_r +: 4]};
    assign cur_step = cur_step_nib;
    assign acc_sum = acc_r + {6'h00, conv_result};
    assign avg_done = (avg_cnt_r + 7'd1 == 7'(1 << avg_r));
    assign step_last = cur_step.ctl[`ADSQ_CTL_END]
                       || ({1'b0, step_r} + 4'd1 == seq_depth(cur_r));
    assign push_data = 10'(acc_sum >> avg_r);

    always_comb begin
        push = 4'h0;
        ris_set = 4'h0;
        if (state_r == ADSQ_WAIT && conv_done && avg_done) begin
            push[cur_r] = 1'b1;
            ris_set[cur_r] = cur_step.ctl[`ADSQ_CTL_IE];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ADSQ_IDLE;
            cur_r <= 2'd0;
            step_r <= 3'd0;
            avg_cnt_r <= 7'd0;
            acc_r <= 16'h0000;
            conv_start <= 1'b0;
            conv_req <= '0;
        end else begin
            conv_start <= 1'b0;
            case (state_r)
                ADSQ_IDLE: begin
                    for (int i = 0; i < NSEQ; i++) begin
                        if (grant[i]) begin
                            cur_r <= 2'(i);
                            step_r <= 3'd0;
                            avg_cnt_r <= 7'd0;
                            acc_r <= 16'h0000;
                            state_r <= ADSQ_START;
                        end
                    end
                end
                ADSQ_START: begin
                    if (tick) begin
                        conv_start <= 1'b1;
                        conv_req.chan <= cur_step.sel;
                        conv_req.diff <= cur_step.ctl[`ADSQ_CTL_DIFF];
                        conv_req.temp <= cur_step.ctl[`ADSQ_CTL_TEMP];
                        state_r <= ADSQ_WAIT;
                    end
                end
                ADSQ_WAIT: begin
                    if (conv_done) begin
                        if (!avg_done) begin
                            acc_r <= acc_sum;
                            avg_cnt_r <= avg_cnt_r + 7'd1;
                        end else begin
                            acc_r <= 16'h0000;
                            avg_cnt_r <= 7'd0;
                        end
                        if (avg_done && step_last) begin
                            state_r <= ADSQ_IDLE;
                        end else begin
                            step_r <= avg_done ? step_r + 3'd1 : step_r;
                            state_r <= ADSQ_START;
                        end
                    end
                end
                default: state_r <= ADSQ_IDLE;
            endcase
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;

endmodule

/* File: adsq_sequencer_properties.sv */
`timescale 1ns/1ns
`include "adsq_params.svh"

module adsq_sequencer_properties
    import adsq_pkg::*;
#(
    parameter int NTRIG = 14,
    parameter int CLK_DIV = 6
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [NTRIG-1:0] trig_in,
    input wire logic conv_start,
    input wire adsq_conv_req_t conv_req,
    input wire logic conv_done,
    input wire logic [9:0] conv_result,
    input wire logic [3:0] seq_irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic busy_r;
    logic [3:0] since_r;
    wire acc = psel & penable & pready & pwrite;
    wire mask_off = acc & (paddr == `ADSQ_OFF_MASK) & (pwdata[3:0] == 4'h0);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_r <= 1'b0;
        end else if (conv_start) begin
            busy_r <= 1'b1;
        end else if (conv_done) begin
            busy_r <= 1'b0;
        end
    end

    // cycles since the last event that may raise an interrupt
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            since_r <= 4'hF;
        end else if (conv_done || acc) begin
            since_r <= 4'h0;
        end else if (since_r != 4'hF) begin
            since_r <= since_r + 4'h1;
        end
    end

    ready_after_setup_a:
        assert property (psel && !penable |=> pready && psel && penable)
        else $error("pready missing after setup");
    ready_pulse_a:
        assert property (pready |-> psel && penable ##1 !pready)
        else $error("pready outside access or too long");
    err_reads_zero_a:
        assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("pslverr without pready or with data");
    start_spacing_a:
        assert property (conv_start |=> !conv_start [*5])
        else $error("conversion starts closer than one tick");
    one_outstanding_a:
        assert property (conv_start |-> !busy_r)
        else $error("conversion started while one is outstanding");
    req_stable_a:
        assert property (!conv_start |-> $stable(conv_req))
        else $error("conversion request changed between starts");
    irq_masked_off_a:
        assert property (mask_off |=> ##1 seq_irq == 4'h0)
        else $error("interrupt output with mask cleared");
    irq_has_cause_a:
        assert property ((seq_irq & ~$past(seq_irq)) != 4'h0 |-> since_r < 4'h8)
        else $error("interrupt rose without a completed step");

    cover property (pslverr);
    cover property (conv_start ##[1:40] conv_done);
    cover property ($rose(seq_irq[0]));
endmodule

bind adsq_sequencer adsq_sequencer_properties #(.NTRIG(NTRIG), .CLK_DIV(CLK_DIV)) u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trig_in(trig_in), .conv_start(conv_start), .conv_req(conv_req),
    .conv_done(conv_done), .conv_result(conv_result), .seq_irq(seq_irq)
);

/* File: adsq_core_model.sv */
`timescale 1ns/1ns

module adsq_core_model
    import adsq_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic conv_start,
    input wire adsq_conv_req_t conv_req,
    input wire logic slow,
    output logic conv_done,
    output logic [9:0] conv_result
);
    int cnt_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 0;
            conv_done <= 1'b0;
            conv_result <= 10'h155;
        end else begin
            conv_done <= 1'b0;
            // no valid data outside the done cycle
            conv_result <= ~conv_result;
            if (conv_start) begin
                cnt_r <= slow ? 20 : 2;
            end else if (cnt_r == 1) begin
                cnt_r <= 0;
                conv_done <= 1'b1;
                conv_result <= {2'b01, conv_req.chan, conv_req.chan};
            end else if (cnt_r != 0) begin
                cnt_r <= cnt_r - 1;
            end
        end
    end
endmodule

/* File: test_adsq_sequencer.sv */
`timescale 1ns/1ns
`include "adsq_params.svh"

module test_adsq_sequencer
    import adsq_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic conv_start, conv_done, slow, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [13:0] trig_in;
    logic [9:0] conv_result;
    logic [3:0] seq_irq;
    adsq_conv_req_t conv_req;
    adsq_conv_req_t chq[$];
    int err_count, n_tests, cyc;

    adsq_sequencer #(.NTRIG(14), .CLK_DIV(6)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .trig_in(trig_in), .conv_start(conv_start),
        .conv_req(conv_req), .conv_done(conv_done), .conv_result(conv_result),
        .seq_irq(seq_irq)
    );
    adsq_core_model core (
        .pclk(pclk), .presetn(presetn), .conv_start(conv_start), .conv_req(conv_req),
        .slow(slow), .conv_done(conv_done), .conv_result(conv_result)
    );

    function automatic logic [11:0] sa(input int n, input int sub);
        return 12'(`ADSQ_OFF_SEQ_BASE + (n << `ADSQ_SEQ_SHIFT) + sub * 4);
    endfunction

    function automatic logic [31:0] fres(input logic [3:0] c);
        return {22'h0, 2'b01, c, c};
    endfunction

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // answer looked at once settled; the next rising edge completes it
        @(negedge pclk);
        while (pready !== 1'b1) @(negedge pclk);
        q = prdata;
        e = pslverr;
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask

    task automatic poll(input logic [11:0] a, input logic [31:0] m, input logic [31:0] v);
        apb(1'b0, a, 32'h0);
        while ((q & m) !== v) apb(1'b0, a, 32'h0);
    endtask

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    always @(negedge pclk) begin
        cyc++;
        if (conv_start === 1'b1) chq.push_back(conv_req);
        if (cyc == 30000) begin
            err_count++;
            test_done();
        end
    end

    initial begin
        {presetn, psel, penable, pwrite, slow} = 5'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        trig_in = 14'h0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(`ADSQ_OFF_PRIO, 32'h0000_3210);
        rd_chk(`ADSQ_OFF_AVG, 32'h0);
        rd_chk(`ADSQ_OFF_RIS, 32'h0);
        apb(1'b0, 12'h01C, 32'hFFFF_FFFF);
        chk({31'h0, e}, 32'h1);
        // three steps, end mid-slot, input reused, later slots ignored
        wr(sa(0, `ADSQ_SUB_MUX), 32'h6666_6522);
        wr(sa(0, `ADSQ_SUB_CTL), 32'h6666_6640);
        wr(`ADSQ_OFF_MASK, 32'h1);
        wr(`ADSQ_OFF_ACTIVE, 32'h1);
        wr(`ADSQ_OFF_SWINIT, 32'h1);
        poll(sa(0, `ADSQ_SUB_FSTAT), 32'hF, 32'h3);
        repeat (40) @(posedge pclk);
        chk(chq.size(), 3);
        rd_chk(sa(0, `ADSQ_SUB_FSTAT), 32'h0000_0003);
        rd_chk(sa(0, `ADSQ_SUB_FIFO), fres(4'h2));
        rd_chk(sa(0, `ADSQ_SUB_FIFO), fres(4'h2));
        rd_chk(sa(0, `ADSQ_SUB_FIFO), fres(4'h5));
        rd_chk(sa(0, `ADSQ_SUB_FSTAT), 32'h0000_0133);
        rd_chk(`ADSQ_OFF_UNF, 32'h0);
        apb(1'b0, sa(0, `ADSQ_SUB_FIFO), 32'h0);
        rd_chk(`ADSQ_OFF_UNF, 32'h1);
        rd_chk(`ADSQ_OFF_RIS, 32'h1);
        rd_chk(`ADSQ_OFF_ISC, 32'h1);
        chk({28'h0, seq_irq}, 32'h1);
        wr(`ADSQ_OFF_ISC, 32'h0);
        rd_chk(`ADSQ_OFF_RIS, 32'h1);
        wr(`ADSQ_OFF_ISC, 32'h1);
        rd_chk(`ADSQ_OFF_RIS, 32'h0);
        chk({28'h0, seq_irq}, 32'h0);
        // one-entry fifo: second result overflows and is dropped
        wr(sa(3, `ADSQ_SUB_MUX), 32'h1);
        wr(sa(3, `ADSQ_SUB_CTL), 32'h2);
        wr(`ADSQ_OFF_ACTIVE, 32'h9);
        wr(`ADSQ_OFF_SWINIT, 32'h8);
        poll(sa(3, `ADSQ_SUB_FSTAT), 32'h1000, 32'h1000);
        wr(`ADSQ_OFF_SWINIT, 32'h8);
        repeat (60) @(posedge pclk);
        rd_chk(`ADSQ_OFF_OVF, 32'h8);
        rd_chk(sa(3, `ADSQ_SUB_FIFO), fres(4'h1));
        wr(`ADSQ_OFF_OVF, 32'h8);
        rd_chk(`ADSQ_OFF_OVF, 32'h0);
        // concurrent triggers, sequencer 2 given the top priority
        slow <= 1'b1;
        wr(sa(1, `ADSQ_SUB_MUX), 32'h4);
        wr(sa(1, `ADSQ_SUB_CTL), 32'hB);
        wr(sa(2, `ADSQ_SUB_MUX), 32'h5);
        wr(sa(2, `ADSQ_SUB_CTL), 32'h2);
        wr(`ADSQ_OFF_PRIO, 32'h0000_3012);
        wr(`ADSQ_OFF_ACTIVE, 32'hF);
        chq.delete();
        wr(`ADSQ_OFF_SWINIT, 32'h6);
        while (chq.size() < 2) @(posedge pclk);
        chk(chq[0].chan, 32'h5);
        chk(chq[1].chan, 32'h4);
        chk({30'h0, chq[0].diff, chq[0].temp}, 32'h0);
        chk({30'h0, chq[1].diff, chq[1].temp}, 32'h3);
        // peripheral trigger line 3 drives sequencer 1
        wr(`ADSQ_OFF_TRIGSEL, 32'h0000_0030);
        chq.delete();
        trig_in <= 14'h0004;
        while (chq.size() < 1) @(posedge pclk);
        chk(chq[0].chan, 32'h4);
        trig_in <= 14'h0;
        // slow conversion of sequencer 1 ends before averaging is changed
        repeat (40) @(posedge pclk);
        // four conversions averaged into one entry
        wr(`ADSQ_OFF_AVG, 32'h2);
        chq.delete();
        wr(`ADSQ_OFF_SWINIT, 32'h8);
        poll(sa(3, `ADSQ_SUB_FSTAT), 32'h1000, 32'h1000);
        repeat (60) @(posedge pclk);
        chk(chq.size(), 4);
        rd_chk(sa(3, `ADSQ_SUB_FIFO), fres(4'h1));
        // always trigger restarts sequencer 3 with no software start
        wr(`ADSQ_OFF_AVG, 32'h0);
        slow <= 1'b0;
        wr(`ADSQ_OFF_TRIGSEL, 32'h0000_F000);
        chq.delete();
        repeat (60) @(posedge pclk);
        chk(32'(chq.size() > 2), 32'h1);
        // disabled sequencers ignore the software start
        wr(`ADSQ_OFF_ACTIVE, 32'h0);
        repeat (20) @(posedge pclk);
        chq.delete();
        wr(`ADSQ_OFF_SWINIT, 32'hF);
        repeat (80) @(posedge pclk);
        chk(chq.size(), 0);
        wr(`ADSQ_OFF_MASK, 32'h0);
        repeat (5) @(posedge pclk);
        test_done();
    end
endmodule
